// ==== inc/adc_seq_params.svh ====
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL_TWO 8'h00
`define OFS_CTRL_THREE 8'h04
`define OFS_INPUT_SELECT 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

// Writable bits of each register
`define MASK_CTRL_TWO 32'h0000f43f
`define MASK_CTRL_THREE 32'h00009fff
`define MASK_INPUT_SELECT 32'h9f9f0000
`define MASK_IRQ 32'h00000003

// Reset values
`define RST_CTRL_TWO 32'h00000000
`define RST_CTRL_THREE 32'h00000000
`define RST_INPUT_SELECT 32'h00000000
`define RST_IRQ_MASK 2'h0

// Control two fields
`define REF_MSB 15
`define REF_LSB 13
`define OFFSET_CALIBRATION_ENABLE_BIT 12
`define SCAN_BIT 10
`define FILL_BIT 7
`define SEQ_MSB 5
`define SEQ_LSB 2
`define SPLIT_BIT 1
`define ALT_BIT 0

// Control three fields
`define CLKSRC_BIT 15
`define SAMT_MSB 12
`define SAMT_LSB 8
`define DIV_MSB 7
`define DIV_LSB 0

// Input select fields
`define NEGB_BIT 31
`define POSB_MSB 28
`define POSB_LSB 24
`define NEGA_BIT 23
`define POSA_MSB 20
`define POSA_LSB 16

// Status and mask bits
`define IRQ_SEQ_BIT 0
`define IRQ_RSVD_BIT 1

// Codes
`define TRIG_AUTO 3'h7
`define POS_LAST_AN 5'h0c
`define POS_TEMP 5'h0d
`define POS_IREF 5'h0e
`define POS_HALF 5'h11

`endif

// ==== inc/adc_seq_pkg.sv ====
package adc_seq_pkg;

  typedef enum logic [1:0]
  {
    SMP_IDLE = 2'b01,
    SMP_RUN = 2'b10
  } sampler_state_e;

  typedef logic [4:0] pos_code_t;

endpackage

// ==== hw/adc_sequence_config_control.sv ====
`timescale 1ns/100ps
`include "adc_seq_params.svh"

module adc_sequence_config_control
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_q,
  input wire logic [2:0] trigger_source,
  input wire logic [4:0] scan_channel,
  input wire logic sample_start,
  input wire logic conv_done,
  input wire logic seq_done,
  input wire logic fast_rc_oscillator,
  output logic high_ref_ext_q,
  output logic low_ref_ext_q,
  output logic sh_to_low_q,
  output logic [4:0] pos_sel_q,
  output logic pos_valid_q,
  output logic neg_an1_q,
  output logic use_b_q,
  output logic scan_active_q,
  output logic split_q,
  output logic fill_upper_q,
  output logic conv_tick_q,
  output logic sample_end_q,
  output logic adc_irq_q,
  output logic irq_q
);

  ////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic rst_s1_q;
  logic rst_n_q;
  logic frc_s1_q;
  logic frc_s2_q;
  logic frc_s3_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      frc_s1_q <= 1'b0;
      frc_s2_q <= 1'b0;
      frc_s3_q <= 1'b0;
    end
    else
    begin
      frc_s1_q <= fast_rc_oscillator;
      frc_s2_q <= frc_s1_q;
      frc_s3_q <= frc_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Codes the multiplexer really has
  function automatic logic pos_ok(input pos_code_t c);
    pos_ok = (c <= `POS_IREF) || (c == `POS_HALF);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] val, input logic [31:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] ctrl_two_q;
  logic [31:0] ctrl_three_q;
  logic [31:0] input_select_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_set;
  logic sel_two;
  logic sel_three;
  logic sel_input;
  logic sel_status;
  logic sel_mask;

  always_comb
  begin
    sel_two = 1'b0;
    sel_three = 1'b0;
    sel_input = 1'b0;
    sel_status = 1'b0;
    sel_mask = 1'b0;
    if (addr == `OFS_CTRL_TWO)
      sel_two = 1'b1;
    else if (addr == `OFS_CTRL_THREE)
      sel_three = 1'b1;
    else if (addr == `OFS_INPUT_SELECT)
      sel_input = 1'b1;
    else if (addr == `OFS_IRQ_STATUS)
      sel_status = 1'b1;
    else if (addr == `OFS_IRQ_MASK)
      sel_mask = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_two_q <= `RST_CTRL_TWO;
      ctrl_three_q <= `RST_CTRL_THREE;
      input_select_q <= `RST_INPUT_SELECT;
      irq_mask_q <= `RST_IRQ_MASK;
    end
    else if (wr_en)
    begin
      if (sel_two)
        ctrl_two_q <= merge(ctrl_two_q, wdata, `MASK_CTRL_TWO);
      else if (sel_three)
        ctrl_three_q <= merge(ctrl_three_q, wdata, `MASK_CTRL_THREE);
      else if (sel_input)
        input_select_q <= merge(input_select_q, wdata, `MASK_INPUT_SELECT);
      else if (sel_mask)
        irq_mask_q <= wdata[1:0];
    end
  end

  // Read of status clears it; a new event in that cycle wins
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_status_q <= 2'h0;
    else if (rd_en && sel_status)
      irq_status_q <= irq_set;
    else
      irq_status_q <= irq_status_q | irq_set;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 32'h0;
    else if (!rd_en)
      rdata_q <= 32'h0;
    else if (sel_two)
      rdata_q <= (ctrl_two_q & `MASK_CTRL_TWO)
        | ({31'h0, fill_upper_q} << `FILL_BIT);
    else if (sel_three)
      rdata_q <= ctrl_three_q & `MASK_CTRL_THREE;
    else if (sel_input)
      rdata_q <= input_select_q & `MASK_INPUT_SELECT;
    else if (sel_status)
      rdata_q <= {30'h0, irq_status_q};
    else if (sel_mask)
      rdata_q <= {30'h0, irq_mask_q};
    else
      rdata_q <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////
  // Field views

  logic [2:0] ref_cfg;
  logic offset_calibration_enable;
  logic scan_en;
  logic [3:0] seq_per_irq;
  logic split_mode;
  logic alt_en;
  logic clk_src_frc;
  logic [4:0] samp_time;
  logic [7:0] clk_div;

  assign ref_cfg = ctrl_two_q[`REF_MSB:`REF_LSB];
  assign offset_calibration_enable = ctrl_two_q[`OFFSET_CALIBRATION_ENABLE_BIT];
  assign scan_en = ctrl_two_q[`SCAN_BIT];
  assign seq_per_irq = ctrl_two_q[`SEQ_MSB:`SEQ_LSB];
  assign split_mode = ctrl_two_q[`SPLIT_BIT];
  assign alt_en = ctrl_two_q[`ALT_BIT];
  assign clk_src_frc = ctrl_three_q[`CLKSRC_BIT];
  assign samp_time = ctrl_three_q[`SAMT_MSB:`SAMT_LSB];
  assign clk_div = ctrl_three_q[`DIV_MSB:`DIV_LSB];

  ////////////////////////////////////////////////////////////////
  // Conversion clock

  logic [8:0] div_cnt_q;
  logic [8:0] div_last;
  logic bus_tick;
  logic frc_tick;

  assign div_last = {clk_div, 1'b1};
  assign bus_tick = (div_cnt_q == div_last);
  assign frc_tick = frc_s2_q && !frc_s3_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      div_cnt_q <= 9'h0;
    else if (clk_src_frc || bus_tick)
      div_cnt_q <= 9'h0;
    else
      div_cnt_q <= div_cnt_q + 9'h1;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      conv_tick_q <= 1'b0;
    else
      conv_tick_q <= clk_src_frc ? frc_tick : bus_tick;
  end

  ////////////////////////////////////////////////////////////////
  // Auto-sample timer

  sampler_state_e smp_state_q;
  logic [4:0] smp_cnt_q;
  logic smp_last;

  assign smp_last = (smp_cnt_q + 5'h1 >= samp_time);

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      smp_state_q <= SMP_IDLE;
      smp_cnt_q <= 5'h0;
      sample_end_q <= 1'b0;
    end
    else
    begin
      sample_end_q <= 1'b0;
      case (smp_state_q)
        SMP_IDLE:
        begin
          smp_cnt_q <= 5'h0;
          if (sample_start && trigger_source == `TRIG_AUTO)
            smp_state_q <= SMP_RUN;
        end
        SMP_RUN:
        begin
          if (trigger_source != `TRIG_AUTO)
            smp_state_q <= SMP_IDLE;
          else if (conv_tick_q && smp_last)
          begin
            sample_end_q <= 1'b1;
            smp_state_q <= SMP_IDLE;
          end
          else if (conv_tick_q)
            smp_cnt_q <= smp_cnt_q + 5'h1;
        end
        default:
          smp_state_q <= SMP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequence pacing and buffer halves

  logic [3:0] seq_cnt_q;
  logic irq_hit;

  assign irq_hit = seq_done && (seq_cnt_q >= seq_per_irq);

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      seq_cnt_q <= 4'h0;
    else if (irq_hit)
      seq_cnt_q <= 4'h0;
    else if (seq_done)
      seq_cnt_q <= seq_cnt_q + 4'h1;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      adc_irq_q <= 1'b0;
    else
      adc_irq_q <= irq_hit;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      fill_upper_q <= 1'b0;
    else if (!split_mode)
      fill_upper_q <= 1'b0;
    else if (irq_hit)
      fill_upper_q <= !fill_upper_q;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      split_q <= 1'b0;
    else
      split_q <= split_mode;
  end

  ////////////////////////////////////////////////////////////////
  // Alternate A/B setting

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      use_b_q <= 1'b0;
    else if (!alt_en)
      use_b_q <= 1'b0;
    else if (conv_done)
      use_b_q <= !use_b_q;
  end

  ////////////////////////////////////////////////////////////////
  // Reference and input multiplexer

  pos_code_t pos_fixed;
  pos_code_t pos_next;
  logic neg_fixed;

  always_comb
  begin
    pos_fixed = input_select_q[`POSA_MSB:`POSA_LSB];
    neg_fixed = input_select_q[`NEGA_BIT];
    if (use_b_q)
    begin
      pos_fixed = input_select_q[`POSB_MSB:`POSB_LSB];
      neg_fixed = input_select_q[`NEGB_BIT];
    end
    pos_next = scan_en ? scan_channel : pos_fixed;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      high_ref_ext_q <= 1'b0;
      low_ref_ext_q <= 1'b0;
    end
    else
    begin
      high_ref_ext_q <= !ref_cfg[2] && ref_cfg[0];
      low_ref_ext_q <= !ref_cfg[2] && ref_cfg[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sh_to_low_q <= 1'b0;
      pos_sel_q <= 5'h0;
      pos_valid_q <= 1'b1;
      neg_an1_q <= 1'b0;
      scan_active_q <= 1'b0;
    end
    else
    begin
      sh_to_low_q <= offset_calibration_enable;
      pos_sel_q <= pos_next;
      pos_valid_q <= offset_calibration_enable || pos_ok(pos_next);
      neg_an1_q <= !offset_calibration_enable && neg_fixed;
      scan_active_q <= scan_en && !offset_calibration_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt events

  assign irq_set[`IRQ_SEQ_BIT] = irq_hit;
  assign irq_set[`IRQ_RSVD_BIT] = sample_start && !offset_calibration_enable && !pos_ok(pos_next);

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_status_q & irq_mask_q);
  end

endmodule

// ==== verification/adc_front_model.sv ====
`timescale 1ns/100ps
module adc_front_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [3:0] dly,
  output logic sample_start,
  output logic conv_done,
  output logic seq_done
);
  logic run_q;
  logic [3:0] cnt_q;

  // Starts sampling on request, reports the finished conversion dly+1 cycles after sample_start
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      run_q <= 1'b0;
      cnt_q <= 4'h0;
      sample_start <= 1'b0;
      conv_done <= 1'b0;
      seq_done <= 1'b0;
    end
    else
    begin
      sample_start <= go && !run_q;
      conv_done <= run_q && cnt_q == 4'h0;
      seq_done <= run_q && cnt_q == 4'h0;
      if (go && !run_q)
      begin
        run_q <= 1'b1;
        cnt_q <= dly;
      end
      else if (run_q)
      begin
        run_q <= cnt_q != 4'h0;
        cnt_q <= cnt_q - 4'h1;
      end
    end
endmodule

// ==== verification/adc_seq_monitor.sv ====
`timescale 1ns/100ps
`include "adc_seq_params.svh"
module adc_seq_monitor
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata_q,
  input wire logic seq_done,
  input wire logic high_ref_ext_q,
  input wire logic low_ref_ext_q,
  input wire logic sh_to_low_q,
  input wire logic [4:0] pos_sel_q,
  input wire logic pos_valid_q,
  input wire logic neg_an1_q,
  input wire logic scan_active_q,
  input wire logic split_q,
  input wire logic fill_upper_q,
  input wire logic conv_tick_q,
  input wire logic adc_irq_q
);
  logic [31:0] c2_q, c3_q;
  logic [9:0] gap_q;
  logic ok_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      c2_q <= 32'h0;
    else if (wr_en && addr == `OFS_CTRL_TWO)
      c2_q <= wdata;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      c3_q <= 32'h0;
    else if (wr_en && addr == `OFS_CTRL_THREE)
      c3_q <= wdata;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      gap_q <= 10'h0;
    else
      gap_q <= conv_tick_q ? 10'h0 : gap_q + 10'h1;

  // Period is trusted only from the second tick after a divisor write
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      ok_q <= 1'b0;
    else if (wr_en && addr == `OFS_CTRL_THREE)
      ok_q <= 1'b0;
    else if (conv_tick_q)
      ok_q <= 1'b1;

  ////////////////////////////////
  a_read_idle: assert property (!$past(rd_en) || $past(addr) > 8'h10 |-> rdata_q == 32'h0)
    else $error("read data not zero");
  a_ref_select: assert property ({high_ref_ext_q, low_ref_ext_q} ==
    ($past(c2_q[15]) ? 2'b00 : {$past(c2_q[13]), $past(c2_q[14])}))
    else $error("reference select wrong");
  a_offset_calibration_enable_tie: assert property (sh_to_low_q == $past(c2_q[12]) && !(sh_to_low_q && neg_an1_q))
    else $error("offset calibration wrong");
  a_scan_follow: assert property (scan_active_q == ($past(c2_q[10]) && !$past(c2_q[12])))
    else $error("scan enable wrong");
  a_split_follow: assert property (split_q == $past(c2_q[1]))
    else $error("split mode wrong");
  a_fill_idle: assert property (!$past(c2_q[1]) |-> !fill_upper_q)
    else $error("fill status set outside split mode");
  a_tick_period: assert property (conv_tick_q && ok_q && !c3_q[15] |->
    gap_q == {1'b0, c3_q[7:0], 1'b1})
    else $error("conversion clock period wrong");
  a_irq_cause: assert property (adc_irq_q |-> $past(seq_done))
    else $error("interrupt without sequence end");
  a_code_valid: assert property (!sh_to_low_q |->
    pos_valid_q == !(pos_sel_q inside {[5'h0f:5'h10], [5'h12:5'h1f]}))
    else $error("positive code validity wrong");
endmodule

// ==== verification/adc_sequence_config_control_test.sv ====
`timescale 1ns/100ps
`include "adc_seq_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module adc_sequence_config_control_test;
  logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, go = 1'b0, rc_on = 1'b0;
  logic rd_p = 1'b0, fill = 1'b0, fast_rc_oscillator = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, v, rdata_q;
  logic [2:0] trigger_source = 3'h0;
  logic [4:0] scan_channel = 5'h0, pos_sel_q;
  logic [3:0] dly = 4'h0;
  logic sample_start, conv_done, seq_done, high_ref_ext_q, low_ref_ext_q, sh_to_low_q;
  logic pos_valid_q, neg_an1_q, use_b_q, scan_active_q, split_q, fill_upper_q;
  logic conv_tick_q, sample_end_q, adc_irq_q, irq_q;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  int num_errors = 0, cmp_count = 0, cyc = 0, gap = 0, last_gap = 0, ticks = 0, rc_cnt = 0;
  int ts = 0, samp = 0, irqs = 0, ends = 0, e0 = 0;
  int dv[3] = '{0, 3, 255};
  int pv[3] = '{0, 3, 15};
  integer seed = 32'hd2c1;

  always #12.5 clk = ~clk;
  // Fast RC pin toggles every 5 clock cycles, a period of 10 cycles
  always @(posedge clk)
    if (rc_on)
    begin
      rc_cnt = (rc_cnt + 1) % 5;
      if (rc_cnt == 0)
        fast_rc_oscillator <= ~fast_rc_oscillator;
    end

  adc_sequence_config_control i_dut (.clk, .rst_b, .addr, .wdata, .wr_en, .rd_en, .rdata_q,
    .trigger_source, .scan_channel, .sample_start, .conv_done, .seq_done, .fast_rc_oscillator,
    .high_ref_ext_q, .low_ref_ext_q, .sh_to_low_q, .pos_sel_q, .pos_valid_q, .neg_an1_q,
    .use_b_q, .scan_active_q, .split_q, .fill_upper_q, .conv_tick_q, .sample_end_q,
    .adc_irq_q, .irq_q);
  adc_front_model i_front (.clk, .rst_b, .go, .dly, .sample_start, .conv_done, .seq_done);

  ////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    gap++;
    if (conv_tick_q)
    begin
      last_gap = gap;
      gap = 0;
      ticks++;
    end
    if (sample_start)
      ts = ticks;
    if (sample_end_q)
    begin
      samp = ticks - ts;
      ends++;
    end
    if (adc_irq_q)
      irqs++;
    if (rd_p)
    begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_q, exp_v)
    end
    rd_p = rd_en;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim;
    end
  end

  ////////////////////////////////
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task seq(input int n);
    repeat (n)
    begin
      @(posedge clk);
      go <= 1'b1;
      dly <= 4'($random(seed) & 7);
      @(posedge clk);
      go <= 1'b0;
      wt(12);
    end
  endtask

  task chk_mux(input logic [4:0] c, input logic n, input logic b);
    `CHK(use_b_q, b)
    `CHK(pos_sel_q, c)
    `CHK(pos_valid_q, c <= 5'h0e || c == 5'h11)
    `CHK(neg_an1_q, n)
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////
  initial
  begin
    wt(5);
    rst_b <= 1'b1;
    wt(3);
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 32'h0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    repeat (8)
    begin
      v = $random(seed);
      wr(`OFS_CTRL_TWO, v);
      wr(`OFS_CTRL_THREE, v | 32'h100);
      wr(`OFS_INPUT_SELECT, v);
      rd(`OFS_CTRL_TWO, v & `MASK_CTRL_TWO);
      rd(`OFS_CTRL_THREE, (v | 32'h100) & `MASK_CTRL_THREE);
      rd(`OFS_INPUT_SELECT, v & `MASK_INPUT_SELECT);
    end
    $display("register test done");
    for (int r = 0; r < 8; r++)
    begin
      wr(`OFS_CTRL_TWO, r << 13);
      wt(2);
      `CHK({high_ref_ext_q, low_ref_ext_q}, r < 4 ? {r[0], r[1]} : 2'b00)
    end
    wr(`OFS_CTRL_TWO, 32'h1);
    for (int i = 0; i < 32; i++)
    begin
      wr(`OFS_INPUT_SELECT, {~i[0], 2'h0, ~i[4:0], i[0], 2'h0, i[4:0], 16'h0});
      wt(3);
      chk_mux(i[4:0], i[0], 1'b0);
      seq(1);
      chk_mux(~i[4:0], ~i[0], 1'b1);
      seq(1);
    end
    scan_channel <= 5'h09;
    wr(`OFS_CTRL_TWO, 32'h0400);
    wt(3);
    `CHK(scan_active_q, 1'b1)
    `CHK(pos_sel_q, 5'h09)
    wr(`OFS_CTRL_TWO, 32'h1401);
    wt(3);
    `CHK({sh_to_low_q, scan_active_q, neg_an1_q}, 3'b100)
    $display("mux test done");
    foreach (dv[k])
    begin
      wr(`OFS_CTRL_THREE, 32'h0300 | dv[k]);
      wt(1040);
      `CHK(last_gap, 2 * (dv[k] + 1))
    end
    wr(`OFS_CTRL_THREE, 32'h83ff);
    rc_on <= 1'b1;
    wt(100);
    `CHK(last_gap, 10)
    rc_on <= 1'b0;
    $display("clock test done");
    wr(`OFS_INPUT_SELECT, 32'h0);
    `CHK(irq_q, 1'b0)
    rd(`OFS_IRQ_STATUS, 32'h3);
    for (int s = 1; s < 32; s += 30)
      for (int t = 0; t < 8; t++)
      begin
        wr(`OFS_CTRL_THREE, s << 8);
        trigger_source <= t[2:0];
        e0 = ends;
        seq(1);
        wt(70);
        `CHK(ends - e0, int'(t == 7))
        if (t == 7)
          `CHK(samp, s)
      end
    $display("sample test done");
    rd(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h1);
    foreach (pv[k])
    begin
      wr(`OFS_CTRL_TWO, (pv[k] << 2) | 2);
      e0 = irqs;
      seq(pv[k]);
      `CHK(irqs - e0, 0)
      seq(1);
      `CHK(irqs - e0, 1)
      fill = ~fill;
      `CHK(fill_upper_q, fill)
      `CHK(irq_q, 1'b1)
      rd(`OFS_CTRL_TWO, 32'((pv[k] << 2) | 2) | {24'h0, fill, 7'h0});
      rd(`OFS_IRQ_STATUS, 32'h1);
      wt(3);
      `CHK(irq_q, 1'b0)
    end
    $display("pacing test done");
    end_sim;
  end
endmodule

bind adc_sequence_config_control adc_seq_monitor i_mon (.clk, .rst_b, .addr, .wdata, .wr_en,
  .rd_en, .rdata_q, .seq_done, .high_ref_ext_q, .low_ref_ext_q, .sh_to_low_q, .pos_sel_q,
  .pos_valid_q, .neg_an1_q, .scan_active_q, .split_q, .fill_upper_q, .conv_tick_q, .adc_irq_q);
